// File: src/qct_defines.svh
// Register offsets, field positions and reset values of the quad compare timer.
// Assumes byte addresses on a 32-bit register bus, one aligned word per register.
`ifndef QCT_DEFINES_SVH
`define QCT_DEFINES_SVH

`define QCT_ADDR_W 8
`define QCT_OFF_CTL0 8'h00
`define QCT_OFF_CTL1 8'h04
`define QCT_OFF_IOC0 8'h08
`define QCT_OFF_IOC1 8'h0c
`define QCT_OFF_IOC2 8'h10
`define QCT_OFF_CNT 8'h14
`define QCT_OFF_CCR0 8'h18
`define QCT_OFF_CCR3 8'h24
`define QCT_OFF_STAT 8'h28
`define QCT_OFF_MASK 8'h2c

`define QCT_CTL0_RUN 7
`define QCT_CTL0_WMASK 8'h87
`define QCT_CTL1_EXT 0
`define QCT_CTL1_WMASK 8'h01
`define QCT_IOC0_WMASK 8'hff
`define QCT_IOC1_WMASK 8'h0f
`define QCT_IOC2_WMASK 8'h03

`define QCT_CNT_IDLE 16'hffff
`define QCT_CNT_ZERO 16'h0000
`define QCT_CCR_RST 16'h0000
`define QCT_REG8_RST 8'h00
`define QCT_STAT_W 6

`define QCT_RESP_OKAY 2'b00
`define QCT_RESP_SLVERR 2'b10

`endif

// File: src/qct_edge_det.sv
// Valid-edge detector for a capture or event input.
// Assumes the input is synchronous to aclk; the pulse is combinational.
`timescale 1ns/100ps
`default_nettype none

module qct_edge_det (
  input wire logic aclk,    // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  qct_edge_if.det e         // Level in, selection in, pulse out.
);
  logic prev_r, prev_nxt;
  logic rise, fall;

  always_comb begin
    prev_nxt = e.sig;
    rise = e.sig & ~prev_r;
    fall = ~e.sig & prev_r;
    case (e.sel)
      qct_pkg::QCT_EDGE_RISING: e.pulse = rise;
      qct_pkg::QCT_EDGE_FALLING: e.pulse = fall;
      qct_pkg::QCT_EDGE_BOTH: e.pulse = rise | fall;
      default: e.pulse = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule // qct_edge_det

`default_nettype wire

// File: src/qct_edge_if.sv
// Connection between the timer core and one edge detector.
// Assumes the input level is synchronous to the detector's clock.
`timescale 1ns/100ps
`default_nettype none

interface qct_edge_if;
  logic sig;
  qct_pkg::qct_edge_t sel;
  logic pulse;
  modport det (input sig, input sel, output pulse);
  modport ctl (output sig, output sel, input pulse);
endinterface

`default_nettype wire

// File: src/qct_pkg.sv
// Types shared by the quad compare timer modules.
// Assumes the offsets and field positions come from qct_defines.svh.
package qct_pkg;

  typedef enum logic [1:0] {
    QCT_EDGE_NONE    = 2'b00,
    QCT_EDGE_RISING  = 2'b01,
    QCT_EDGE_FALLING = 2'b10,
    QCT_EDGE_BOTH    = 2'b11
  } qct_edge_t;

  typedef enum logic [3:0] {
    QCT_R_CTL0 = 4'b0000,
    QCT_R_CTL1 = 4'b0001,
    QCT_R_IOC0 = 4'b0010,
    QCT_R_IOC1 = 4'b0011,
    QCT_R_IOC2 = 4'b0100,
    QCT_R_CNT  = 4'b0101,
    QCT_R_CCR  = 4'b0110,
    QCT_R_STAT = 4'b0111,
    QCT_R_MASK = 4'b1000,
    QCT_R_NONE = 4'b1111
  } qct_reg_t;

endpackage

// File: src/qct_prescaler.sv
// Internal count-clock selector: one of eight divided rates of aclk.
// Assumes the divider restarts whenever run is low.
`timescale 1ns/100ps
`default_nettype none

module qct_prescaler #(
  parameter int DIV_W = 7
) (
  input wire logic aclk,        // Clock.
  input wire logic aresetn,     // Synchronous reset, active low.
  input wire logic run,         // Divider runs while high.
  input wire logic [2:0] sel,   // Rate select, divide by two to the power sel.
  output logic tick             // One-cycle count enable.
);
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [DIV_W-1:0] mask;

  always_comb begin
    mask = DIV_W'(({{DIV_W{1'b0}}, 1'b1} << sel) - 1'b1);
    tick = run & (&(div_r | ~mask));
    div_nxt = run ? DIV_W'(div_r + 1'b1) : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule // qct_prescaler

`default_nettype wire

// File: src/qct_top.sv
// Quad compare timer core with an AXI4-Lite register slave.
// Assumes all pin inputs are synchronous to aclk and one master on the bus.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "qct_defines.svh"
`default_nettype none

module qct_top #(
  parameter int NCH = 4,
  parameter int PRE_W = 7
) (
  input wire logic aclk,                       // Clock, 100 MHz.
  input wire logic aresetn,                    // Synchronous reset, active low.
  input wire logic [`QCT_ADDR_W-1:0] awaddr,   // Write address.
  input wire logic awvalid,                    // Write address valid.
  output logic awready,                        // Write address ready.
  input wire logic [31:0] wdata,               // Write data.
  input wire logic [3:0] wstrb,                // Write byte strobes.
  input wire logic wvalid,                     // Write data valid.
  output logic wready,                         // Write data ready.
  output logic [1:0] bresp,                    // Write response.
  output logic bvalid,                         // Write response valid.
  input wire logic bready,                     // Write response ready.
  input wire logic [`QCT_ADDR_W-1:0] araddr,   // Read address.
  input wire logic arvalid,                    // Read address valid.
  output logic arready,                        // Read address ready.
  output logic [31:0] rdata,                   // Read data.
  output logic [1:0] rresp,                    // Read response.
  output logic rvalid,                         // Read data valid.
  input wire logic rready,                     // Read data ready.
  input wire logic capture_input_ch0,          // Capture input, channel 0.
  input wire logic capture_input_ch3,          // Capture input, channel 3.
  input wire logic event_input,                // External event count input.
  output logic [NCH-1:0] timer_output,         // Timer output pins.
  output logic [NCH-1:0] match_irq,            // Per-channel match pulses.
  output logic irq                             // Combined masked interrupt level.
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic qct_pkg::qct_reg_t qct_decode(input logic [`QCT_ADDR_W-1:0] a);
    if (a == `QCT_OFF_CTL0) begin
      return qct_pkg::QCT_R_CTL0;
    end else if (a == `QCT_OFF_CTL1) begin
      return qct_pkg::QCT_R_CTL1;
    end else if (a == `QCT_OFF_IOC0) begin
      return qct_pkg::QCT_R_IOC0;
    end else if (a == `QCT_OFF_IOC1) begin
      return qct_pkg::QCT_R_IOC1;
    end else if (a == `QCT_OFF_IOC2) begin
      return qct_pkg::QCT_R_IOC2;
    end else if (a == `QCT_OFF_CNT) begin
      return qct_pkg::QCT_R_CNT;
    end else if (a >= `QCT_OFF_CCR0 && a <= `QCT_OFF_CCR3 && a[1:0] == 2'b00) begin
      return qct_pkg::QCT_R_CCR;
    end else if (a == `QCT_OFF_STAT) begin
      return qct_pkg::QCT_R_STAT;
    end else if (a == `QCT_OFF_MASK) begin
      return qct_pkg::QCT_R_MASK;
    end else begin
      return qct_pkg::QCT_R_NONE;
    end
  endfunction

  function automatic logic [1:0] qct_ccr_idx(input logic [`QCT_ADDR_W-1:0] a);
    logic [`QCT_ADDR_W-1:0] d;
    d = `QCT_ADDR_W'(a - `QCT_OFF_CCR0);
    return d[3:2];
  endfunction

  function automatic logic [31:0] qct_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (stb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // State declarations
  // ****************************************************************
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, wdat_r, wdat_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [`QCT_ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [3:0] wstb_r, wstb_nxt;
  logic do_wr;
  qct_pkg::qct_reg_t wsel, rsel;
  logic [31:0] wval;

  logic [7:0] ctl0_r, ctl0_nxt, ctl1_r, ctl1_nxt, ioc0_r, ioc0_nxt;
  logic [7:0] ioc1_r, ioc1_nxt, ioc2_r, ioc2_nxt;
  logic [15:0] ccr_r [NCH];
  logic [15:0] ccr_nxt [NCH];
  logic [`QCT_STAT_W-1:0] mask_r, mask_nxt, stat_r, stat_nxt, stat_clr;

  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] buf_r [NCH];
  logic [15:0] buf_nxt [NCH];
  logic started_r, started_nxt, irq_r, irq_nxt;
  logic [NCH-1:0] tog_r, tog_nxt, tout_r, tout_nxt, mirq_r, mirq_nxt, match, oe, ol;
  logic run, ext, tick, pre_tick;
  logic [2:0] edge_pulse;

  // ****************************************************************
  // Edge detectors and clock selector
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_edge
      qct_edge_if eif();
      if (gi == 0) begin : g_c0
        assign eif.sig = capture_input_ch0;
        assign eif.sel = qct_pkg::qct_edge_t'(ioc1_r[1:0]);
      end else if (gi == 1) begin : g_c3
        assign eif.sig = capture_input_ch3;
        assign eif.sel = qct_pkg::qct_edge_t'(ioc1_r[3:2]);
      end else begin : g_ev
        assign eif.sig = event_input;
        assign eif.sel = qct_pkg::qct_edge_t'(ioc2_r[1:0]);
      end
      assign edge_pulse[gi] = eif.pulse;
      qct_edge_det u_det (.aclk(aclk), .aresetn(aresetn), .e(eif));
    end
  endgenerate

  qct_prescaler #(.DIV_W(PRE_W)) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run & started_r),
    .sel(ctl0_r[2:0]),
    .tick(pre_tick)
  );

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    waddr_nxt = waddr_r;
    wdat_nxt = wdat_r;
    wstb_nxt = wstb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    wsel = qct_decode(waddr_r);
    rsel = qct_decode(araddr);
    do_wr = aw_got_r & w_got_r & ~bvalid_r;
    if (awvalid && awready_r) begin
      awready_nxt = 1'b0;
      aw_got_nxt = 1'b1;
      waddr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      wready_nxt = 1'b0;
      w_got_nxt = 1'b1;
      wdat_nxt = wdata;
      wstb_nxt = wstrb;
    end
    if (do_wr) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wsel == qct_pkg::QCT_R_NONE) ? `QCT_RESP_SLVERR : `QCT_RESP_OKAY;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = `QCT_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (rsel == qct_pkg::QCT_R_CTL0) begin
        rdata_nxt[7:0] = ctl0_r;
      end else if (rsel == qct_pkg::QCT_R_CTL1) begin
        rdata_nxt[7:0] = ctl1_r;
      end else if (rsel == qct_pkg::QCT_R_IOC0) begin
        rdata_nxt[7:0] = ioc0_r;
      end else if (rsel == qct_pkg::QCT_R_IOC1) begin
        rdata_nxt[7:0] = ioc1_r;
      end else if (rsel == qct_pkg::QCT_R_IOC2) begin
        rdata_nxt[7:0] = ioc2_r;
      end else if (rsel == qct_pkg::QCT_R_CNT) begin
        rdata_nxt[15:0] = (run && started_r) ? cnt_r : `QCT_CNT_ZERO;
      end else if (rsel == qct_pkg::QCT_R_CCR) begin
        rdata_nxt[15:0] = ccr_r[qct_ccr_idx(araddr)];
      end else if (rsel == qct_pkg::QCT_R_STAT) begin
        rdata_nxt[`QCT_STAT_W-1:0] = stat_r;
      end else if (rsel == qct_pkg::QCT_R_MASK) begin
        rdata_nxt[`QCT_STAT_W-1:0] = mask_r;
      end else begin
        rresp_nxt = `QCT_RESP_SLVERR;
      end
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= '0;
      wdat_r <= 32'h0000_0000;
      wstb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `QCT_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `QCT_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      waddr_r <= waddr_nxt;
      wdat_r <= wdat_nxt;
      wstb_r <= wstb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_comb begin
    ctl0_nxt = ctl0_r;
    ctl1_nxt = ctl1_r;
    ioc0_nxt = ioc0_r;
    ioc1_nxt = ioc1_r;
    ioc2_nxt = ioc2_r;
    mask_nxt = mask_r;
    ccr_nxt = ccr_r;
    stat_clr = '0;
    wval = 32'h0000_0000;
    if (do_wr) begin
      if (wsel == qct_pkg::QCT_R_CTL0) begin
        ctl0_nxt = 8'(qct_merge({24'h0, ctl0_r}, wdat_r, wstb_r)) & `QCT_CTL0_WMASK;
      end else if (wsel == qct_pkg::QCT_R_CTL1) begin
        ctl1_nxt = 8'(qct_merge({24'h0, ctl1_r}, wdat_r, wstb_r)) & `QCT_CTL1_WMASK;
      end else if (wsel == qct_pkg::QCT_R_IOC0) begin
        ioc0_nxt = 8'(qct_merge({24'h0, ioc0_r}, wdat_r, wstb_r)) & `QCT_IOC0_WMASK;
      end else if (wsel == qct_pkg::QCT_R_IOC1) begin
        ioc1_nxt = 8'(qct_merge({24'h0, ioc1_r}, wdat_r, wstb_r)) & `QCT_IOC1_WMASK;
      end else if (wsel == qct_pkg::QCT_R_IOC2) begin
        ioc2_nxt = 8'(qct_merge({24'h0, ioc2_r}, wdat_r, wstb_r)) & `QCT_IOC2_WMASK;
      end else if (wsel == qct_pkg::QCT_R_CCR) begin
        // Writes are taken whether or not the counter runs.
        wval = qct_merge({16'h0, ccr_r[qct_ccr_idx(waddr_r)]}, wdat_r, wstb_r);
        ccr_nxt[qct_ccr_idx(waddr_r)] = wval[15:0];
      end else if (wsel == qct_pkg::QCT_R_STAT) begin
        stat_clr = `QCT_STAT_W'(qct_merge(32'h0, wdat_r, wstb_r));
      end else if (wsel == qct_pkg::QCT_R_MASK) begin
        mask_nxt = `QCT_STAT_W'(qct_merge({26'h0, mask_r}, wdat_r, wstb_r));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl0_r <= `QCT_REG8_RST;
      ctl1_r <= `QCT_REG8_RST;
      ioc0_r <= `QCT_REG8_RST;
      ioc1_r <= `QCT_REG8_RST;
      ioc2_r <= `QCT_REG8_RST;
      mask_r <= '0;
      for (int n = 0; n < NCH; n++) begin
        ccr_r[n] <= `QCT_CCR_RST;
      end
    end else begin
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
      ioc0_r <= ioc0_nxt;
      ioc1_r <= ioc1_nxt;
      ioc2_r <= ioc2_nxt;
      mask_r <= mask_nxt;
      ccr_r <= ccr_nxt;
    end
  end

  // ****************************************************************
  // Counter, compare channels, outputs and interrupts
  // ****************************************************************
  always_comb begin
    run = ctl0_r[`QCT_CTL0_RUN];
    ext = ctl1_r[`QCT_CTL1_EXT];
    tick = ext ? edge_pulse[2] : pre_tick;
    started_nxt = run;
    if (!run) begin
      cnt_nxt = `QCT_CNT_IDLE;
    end else if (!started_r) begin
      cnt_nxt = `QCT_CNT_ZERO;
    end else if (tick) begin
      cnt_nxt = 16'(cnt_r + 16'h0001);
    end else begin
      cnt_nxt = cnt_r;
    end
    for (int n = 0; n < NCH; n++) begin
      oe[n] = ioc0_r[2*n];
      ol[n] = ioc0_r[2*n+1];
      buf_nxt[n] = ccr_r[n];
      match[n] = run & started_r & tick & (cnt_r == buf_r[n]);
      tog_nxt[n] = run ? (tog_r[n] ^ (match[n] & oe[n])) : 1'b0;
      tout_nxt[n] = oe[n] & (tog_nxt[n] ^ ol[n]);
    end
    mirq_nxt = match;
    // A new event beats a clear written in the same cycle.
    stat_nxt = (stat_r & ~stat_clr) | {edge_pulse[1:0], match};
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= `QCT_CNT_IDLE;
      started_r <= 1'b0;
      tog_r <= '0;
      tout_r <= '0;
      mirq_r <= '0;
      stat_r <= '0;
      irq_r <= 1'b0;
      for (int n = 0; n < NCH; n++) begin
        buf_r[n] <= `QCT_CCR_RST;
      end
    end else begin
      cnt_r <= cnt_nxt;
      started_r <= started_nxt;
      tog_r <= tog_nxt;
      tout_r <= tout_nxt;
      mirq_r <= mirq_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      buf_r <= buf_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign timer_output = tout_r;
  assign match_irq = mirq_r;
  assign irq = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_idle_all_ones: assert property (!run |=> cnt_r == 16'hffff)
    else $error("Counter not at all ones while stopped.");
  a_reset_stops: assert property (disable iff (1'b0) !aresetn |=> !ctl0_r[7] && cnt_r == 16'hffff)
    else $error("Reset did not stop the counter.");
  a_start_zero: assert property ($rose(started_r) && run |-> cnt_r == 16'h0000)
    else $error("Counter did not step to zero at start.");
  a_count_step: assert property (run && started_r && tick ##1 run |-> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("Counter did not advance by one.");
  a_count_hold: assert property (run && started_r && !tick ##1 run |-> $stable(cnt_r))
    else $error("Counter moved without a count event.");
  a_match_pulse: assert property (match[1] |=> match_irq[1] && stat_r[1])
    else $error("Channel one match did not pulse its request.");
  a_pin_toggle: assert property (run && match[1] && oe[1] && $stable(ioc0_r) |=>
      timer_output[1] != $past(timer_output[1]))
    else $error("Channel one output did not invert on match.");
  a_buf_follow: assert property (do_wr && waddr_r == `QCT_OFF_CCR0 + 8'h04 && wstb_r == 4'hf |=>
      ##1 buf_r[1] == 16'($past(wdat_r, 2)))
    else $error("Compare buffer did not take the written value.");
  a_stopped_read: assert property (arvalid && arready && rsel == qct_pkg::QCT_R_CNT && !run |=> rdata == 32'h0000_0000)
    else $error("Count read while stopped was not zero.");
  a_ccr_reset: assert property (disable iff (1'b0) !aresetn |=> ccr_r[1] == 16'h0000 && buf_r[1] == 16'h0000)
    else $error("Compare register or buffer not cleared by reset.");

endmodule // qct_top

`default_nettype wire

// File: test/qct_pin_model.sv
// Pin-side partner of the timer: drives the event and capture input pins.
// Assumes the bench gates it with levels that change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module qct_pin_model (
  input wire logic aclk,          // Clock.
  input wire logic ev_go,         // Event pin toggles at each edge while high.
  input wire logic cap_go,        // Both capture pins toggle at each edge while high.
  output logic event_input,       // External event pin.
  output logic capture_input_ch0, // Capture pin, channel 0.
  output logic capture_input_ch3  // Capture pin, channel 3.
);
  initial begin
    event_input = 1'b0;
    capture_input_ch0 = 1'b0;
    capture_input_ch3 = 1'b0;
  end

  // Pins change only on edges, so every level lasts whole cycles.
  always @(posedge aclk) begin
    if (ev_go) event_input <= ~event_input;
    if (cap_go) begin
      capture_input_ch0 <= ~capture_input_ch0;
      capture_input_ch3 <= ~capture_input_ch3;
    end
  end
endmodule // qct_pin_model

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench of the quad compare timer over its register bus.
// Assumes qct_top with the byte offsets of qct_defines.svh and the pin model.
`timescale 1ns/100ps
`include "qct_defines.svh"
`default_nettype none

module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ev_go, cap_go;
  logic awready, wready, bvalid, arready, rvalid, irq, ev, c0, c3;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, tout, mirq;
  logic [1:0] bresp, rresp;
  int miscompares, total_checks;

  qct_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capture_input_ch0(c0), .capture_input_ch3(c3), .event_input(ev),
    .timer_output(tout), .match_irq(mirq), .irq(irq));
  qct_pin_model pins (.aclk(aclk), .ev_go(ev_go), .cap_go(cap_go), .event_input(ev),
    .capture_input_ch0(c0), .capture_input_ch3(c3));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Each bus wait lasts until the slave answers and only the watchdog ends its hang; wait_match gives up after 1200 cycles.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic v;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      v = bvalid;
      r = bresp;
    end while (v !== 1'b1);
    bready <= 1'b0;
    chk({29'h0, v, r}, {29'h0, 1'b1, `QCT_RESP_OKAY}, "write answer");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic v;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      v = rvalid;
      r = rresp;
      d = rdata;
    end while (v !== 1'b1);
    rready <= 1'b0;
    chk({29'h0, v, r}, {29'h0, 1'b1, er}, "read answer");
    chk(d, exp, "read data");
  endtask

  task automatic wait_match(input int ch, input logic [3:0] pins_exp);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (mirq[ch] !== 1'b1 && n < 1200);
    chk({24'h0, mirq, tout}, {24'h0, 4'h1 << ch, pins_exp}, "match pulse and pins");
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge aclk);
    #1 chk({31'h0, irq}, {31'h0, e}, "interrupt level");
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; ev_go = 1'b0; cap_go = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hf; miscompares = 0; total_checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`QCT_OFF_CNT, 32'h0, `QCT_RESP_OKAY);
    for (int i = 0; i < 4; i++) rdc(`QCT_OFF_CCR0 + 8'(4 * i), 32'h0, `QCT_RESP_OKAY);
    rdc(8'h30, 32'h0, `QCT_RESP_SLVERR);
    $display("reset test done");
    wr(`QCT_OFF_IOC0, 32'h55);
    wr(`QCT_OFF_MASK, 32'h0f);
    for (int i = 0; i < 4; i++) wr(`QCT_OFF_CCR0 + 8'(4 * i), 32'h100 * (i + 1));
    wr(`QCT_OFF_CTL0, 32'h80);
    for (int i = 0; i < 4; i++) wait_match(i, 4'hf >> (3 - i));
    rdc(`QCT_OFF_STAT, 32'h0f, `QCT_RESP_OKAY);
    irq_is(1'b1);
    wr(`QCT_OFF_STAT, 32'h0f);
    irq_is(1'b0);
    wr(`QCT_OFF_CCR0 + 8'h04, 32'h500);
    rdc(`QCT_OFF_CCR0 + 8'h04, 32'h500, `QCT_RESP_OKAY);
    wait_match(1, 4'hd);
    $display("compare test done");
    wr(`QCT_OFF_CTL1, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(`QCT_OFF_CTL0, 32'h0);
      rdc(`QCT_OFF_CNT, 32'h0, `QCT_RESP_OKAY);
      wr(`QCT_OFF_IOC2, 32'(c));
      wr(`QCT_OFF_CTL0, 32'h80);
      ev_go <= 1'b1;
      repeat (20) @(posedge aclk);
      ev_go <= 1'b0;
      rdc(`QCT_OFF_CNT, (c == 0) ? 32'd0 : (c == 3) ? 32'd20 : 32'd10, `QCT_RESP_OKAY);
    end
    $display("event test done");
    wr(`QCT_OFF_CTL0, 32'h0);
    wr(`QCT_OFF_CTL1, 32'h0);
    wr(`QCT_OFF_CTL0, 32'h82);
    repeat (40) @(posedge aclk);
    rdc(`QCT_OFF_CNT, 32'd10, `QCT_RESP_OKAY);
    wr(`QCT_OFF_CTL0, 32'h0);
    wr(`QCT_OFF_IOC0, 32'hff);
    @(posedge aclk);
    chk({28'h0, tout}, 32'h0000_000f, "pins while stopped");
    $display("prescaler test done");
    wr(`QCT_OFF_MASK, 32'h0);
    wr(`QCT_OFF_IOC1, 32'h05);
    cap_go <= 1'b1;
    @(posedge aclk);
    cap_go <= 1'b0;
    rdc(`QCT_OFF_STAT, 32'h32, `QCT_RESP_OKAY);
    irq_is(1'b0);
    wr(`QCT_OFF_MASK, 32'h30);
    irq_is(1'b1);
    wr(`QCT_OFF_STAT, 32'h32);
    irq_is(1'b0);
    rdc(`QCT_OFF_STAT, 32'h0, `QCT_RESP_OKAY);
    $display("interrupt test done");
    report_and_stop;
  end
endmodule // tb_top

`default_nettype wire
